// >>> core/dcc_pkg.sv
`default_nettype none

package dcc_pkg;

   // Time-base and capture width, and the coherent pair read out as one word.
   localparam int unsigned TB_W   = 16;
   localparam int unsigned PAIR_W = 32;
   localparam int unsigned MASK_W = 4;

   // Values after reset and counter boundary values.
   localparam logic [TB_W-1:0]   TB_ZERO  = 16'h0000;
   localparam logic [TB_W-1:0]   TB_ONES  = 16'hffff;
   localparam logic [MASK_W-1:0] MASK_RST = 4'h0;

   // Double-action channel operating modes.
   typedef enum logic [2:0] {
      DA_OFF,
      DA_PULSE_WIDTH,
      DA_PERIOD,
      DA_ONE_SHOT,
      DA_PWM
   } dcc_da_mode_t;

   // Output flip-flop action on a single-action compare match.
   typedef enum logic [1:0] {
      SA_TOGGLE,
      SA_FORCE_HIGH,
      SA_FORCE_LOW
   } dcc_sa_act_t;

   // Counter unit configuration.
   typedef struct packed {
      logic src_ext;     // 1: count pin edges, 0: count prescaler ticks.
      logic ext_rise;    // Pin edge counted when src_ext is set.
      logic ovf_irq_en;  // Overflow request enable.
   } dcc_cnt_cfg_t;

   // Double-action channel configuration.
   typedef struct packed {
      dcc_da_mode_t      mode;
      logic              tb_sel;        // 1: modulus unit bus, 0: free-running unit bus.
      logic              lead_rise;     // Leading edge is rising (and drives high on output).
      logic              irq_en;
      logic              first_irq_en;
      logic              irq_every_edge;
      logic [MASK_W-1:0] mask_bits;     // High-order time-base bits ignored in compares.
   } dcc_da_cfg_t;

   // Single-action channel configuration.
   typedef struct packed {
      logic        compare;   // 1: output compare, 0: input capture.
      logic        tb_sel;
      logic        cap_rise;
      dcc_sa_act_t action;
      logic        irq_en;
   } dcc_sa_cfg_t;

   // Matched pair of edge samples, primary register in the upper half.
   typedef struct packed {
      logic [TB_W-1:0] primary;
      logic [TB_W-1:0] second;
   } dcc_pair_t;

   // Compare with the top mask_bits bits of the time-base treated as don't care.
   function automatic logic masked_match(input logic [TB_W-1:0]   tb,
                                         input logic [TB_W-1:0]   val,
                                         input logic [MASK_W-1:0] mask_bits);
      logic [TB_W-1:0] keep;
      keep = TB_ONES >> mask_bits;
      return ((tb ^ val) & keep) == TB_ZERO;
   endfunction

endpackage

`default_nettype wire

// >>> core/dcc_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a pin, followed by an edge detector on the safe stage.
module dcc_edge_sync
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   // The first stage feeds only the second. The chain is not cleared: it fills with the pin's real
   // level while reset is held (three cycles at least), so a pin idling high gives no false edge.
   always_ff @(posedge clk_i)
   begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
   end

   // Edge pulses last one cycle, two cycles after the pin is first sampled.
   assign level_o = sync_r;
   assign rise_o  = sync_r & ~prev_r;
   assign fall_o  = ~sync_r & prev_r;

   chk_rise_latency : assert property (@(posedge clk_i) disable iff (rst_i)
      rise_o |-> $past(pin_i, 2) && !$past(pin_i, 3))
      else $error("Rising edge reported without matching pin history.");

endmodule
`default_nettype wire

// >>> core/dcc_counter_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Time-base counter; with IS_MOD set it reloads from the modulus on overflow.
module dcc_counter_unit
   import dcc_pkg::*;
#(
   parameter bit IS_MOD = 1'b0
)
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire dcc_pkg::dcc_cnt_cfg_t cfg_i,
   input  wire logic                  presc_tick_i,
   input  wire logic                  ext_rise_i,
   input  wire logic                  ext_fall_i,
   input  wire logic                  load_i,
   input  wire logic [dcc_pkg::TB_W-1:0] load_val_i,
   input  wire logic [dcc_pkg::TB_W-1:0] modulus_i,
   output logic [dcc_pkg::TB_W-1:0]   count_o,
   output logic                       step_o,
   output logic                       ovf_irq_o
);
   logic [TB_W-1:0] count_r;
   logic [TB_W-1:0] count_nxt;
   logic            irq_r;
   wire  logic      ext_step;
   wire  logic      wrap;

   // Pin edges give pulse accumulation; ticks give a time-base.
   assign ext_step = cfg_i.ext_rise ? ext_rise_i : ext_fall_i;
   assign step_o   = ~load_i & (cfg_i.src_ext ? ext_step : presc_tick_i);
   assign wrap     = step_o & (count_r == TB_ONES);

   // Software loads win; a modulus unit restarts from the modulus at overflow.
   assign count_nxt = load_i ? load_val_i :
                      wrap   ? (IS_MOD ? modulus_i : TB_ZERO) :
                      step_o ? count_r + 16'h0001 : count_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_r <= TB_ZERO;
         irq_r   <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         irq_r   <= wrap & cfg_i.ovf_irq_en;
      end
   end

   assign count_o   = count_r;
   assign ovf_irq_o = irq_r;

   chk_ovf_reload : assert property (@(posedge clk_i) disable iff (rst_i)
      wrap |=> count_r == (IS_MOD ? $past(modulus_i) : TB_ZERO))
      else $error("Counter did not restart correctly after overflow.");

   // A modulus of all ones wraps on every step, so back-to-back requests are then legal.
   chk_ovf_request : assert property (@(posedge clk_i) disable iff (rst_i)
      (wrap && cfg_i.ovf_irq_en) |=> ovf_irq_o ##1 (!ovf_irq_o || $past(wrap)))
      else $error("Overflow request not a single pulse after wrap.");

endmodule
`default_nettype wire

// >>> core/dcc_top.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Pulse width: leading edge captures into first stage.
// - Trailing edge: primary captures, first moves to second.
// - Leading sample double latched for one period.
// - Pulse width request after each trailing edge.
// - Optional request after the first captured edge.
// - Primary and second stage read as coherent pair.
// - Samples and compare values are sixteen bits.
// - Period: capture, shift, then primary into first.
// - Period mode request on every new sample.
// - Single channel compares and changes output pin.
// - Match action: toggle, force high, force low.
// - Request when compare completes.
// - One-shot: two edges, polarity, then halt.
// - One-shot request on every or second edge.
// - PWM repeats compares; high time-base bits maskable.
// - PWM leading match copies first into second.
// - Width changes take effect at leading edge.
// - PWM optional request on each leading edge.
// - Duty one to 64K cycles; lead polarity selectable.
// - Modulus time-base sets the PWM period.
// - Counters accumulate pulses, request on overflow.
// - Load two's complement modulus for N pulses.
// - Each channel selects one of two time-bases.
module dcc_top
(
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       presc_tick_i,
   input  wire logic                       cnt_pin_i,
   input  wire dcc_pkg::dcc_cnt_cfg_t      fr_cfg_i,
   input  wire dcc_pkg::dcc_cnt_cfg_t      mc_cfg_i,
   input  wire logic                       fr_load_i,
   input  wire logic                       mc_load_i,
   input  wire logic [dcc_pkg::TB_W-1:0]   cnt_load_val_i,
   input  wire logic [dcc_pkg::TB_W-1:0]   mc_modulus_i,
   output logic [dcc_pkg::TB_W-1:0]        fr_count_o,
   output logic [dcc_pkg::TB_W-1:0]        mc_count_o,
   output logic                            fr_ovf_irq_o,
   output logic                            mc_ovf_irq_o,
   input  wire dcc_pkg::dcc_da_cfg_t       da_cfg_i,
   input  wire logic                       da_wr_a_i,
   input  wire logic                       da_wr_b_i,
   input  wire logic [dcc_pkg::TB_W-1:0]   da_wdata_i,
   input  wire logic                       da_pin_i,
   output logic                            da_pin_o,
   output logic                            da_pin_oe_n_o,
   output dcc_pkg::dcc_pair_t              da_pair_o,
   output logic [dcc_pkg::TB_W-1:0]        da_first_o,
   output logic                            da_irq_o,
   input  wire dcc_pkg::dcc_sa_cfg_t       sa_cfg_i,
   input  wire logic                       sa_wr_i,
   input  wire logic [dcc_pkg::TB_W-1:0]   sa_wdata_i,
   input  wire logic                       sa_pin_i,
   output logic                            sa_pin_o,
   output logic                            sa_pin_oe_n_o,
   output logic [dcc_pkg::TB_W-1:0]        sa_capture_o,
   output logic                            sa_irq_o
);
   import dcc_pkg::*;

   // Synchronised pin edges.
   wire logic cnt_rise;
   wire logic cnt_fall;
   wire logic da_rise;
   wire logic da_fall;
   wire logic sa_rise;
   wire logic sa_fall;

   // Time-base buses and their step pulses.
   wire logic [TB_W-1:0] fr_count;
   wire logic [TB_W-1:0] mc_count;
   wire logic            fr_step;
   wire logic            mc_step;

   // Every pin goes through the same two-flop synchroniser before any use.
   dcc_edge_sync u_cnt_sync
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (cnt_pin_i),
      .level_o (),
      .rise_o  (cnt_rise),
      .fall_o  (cnt_fall)
   );

   dcc_edge_sync u_da_sync
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (da_pin_i),
      .level_o (),
      .rise_o  (da_rise),
      .fall_o  (da_fall)
   );

   dcc_edge_sync u_sa_sync
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (sa_pin_i),
      .level_o (),
      .rise_o  (sa_rise),
      .fall_o  (sa_fall)
   );

   // Free-running unit; it never uses a modulus.
   dcc_counter_unit #(.IS_MOD(1'b0)) u_free_running_counter_unit
   (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .cfg_i        (fr_cfg_i),
      .presc_tick_i (presc_tick_i),
      .ext_rise_i   (cnt_rise),
      .ext_fall_i   (cnt_fall),
      .load_i       (fr_load_i),
      .load_val_i   (cnt_load_val_i),
      .modulus_i    (TB_ZERO),
      .count_o      (fr_count),
      .step_o       (fr_step),
      .ovf_irq_o    (fr_ovf_irq_o)
   );

   // Modulus unit; loading the two's complement of N gives a request after N pulses.
   dcc_counter_unit #(.IS_MOD(1'b1)) u_modulus_counter_unit
   (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .cfg_i        (mc_cfg_i),
      .presc_tick_i (presc_tick_i),
      .ext_rise_i   (cnt_rise),
      .ext_fall_i   (cnt_fall),
      .load_i       (mc_load_i),
      .load_val_i   (cnt_load_val_i),
      .modulus_i    (mc_modulus_i),
      .count_o      (mc_count),
      .step_o       (mc_step),
      .ovf_irq_o    (mc_ovf_irq_o)
   );

   assign fr_count_o = fr_count;
   assign mc_count_o = mc_count;

   // ---- Double-action channel ----

   logic [TB_W-1:0] a_r;
   logic [TB_W-1:0] a_nxt;
   logic [TB_W-1:0] b1_r;
   logic [TB_W-1:0] b1_nxt;
   logic [TB_W-1:0] b2_r;
   logic [TB_W-1:0] b2_nxt;
   logic            copy_r;
   logic            copy_nxt;
   logic            first_r;
   logic            first_nxt;
   logic            a_arm_r;
   logic            a_arm_nxt;
   logic            b_arm_r;
   logic            b_arm_nxt;
   logic            out_r;
   logic            out_nxt;
   logic            irq_r;
   logic            irq_nxt;
   dcc_da_mode_t    mode_q_r;

   // Time-base selection and edge decoding for the double-action channel.
   wire logic [TB_W-1:0] da_tb    = da_cfg_i.tb_sel ? mc_count : fr_count;
   wire logic            da_step  = da_cfg_i.tb_sel ? mc_step : fr_step;
   wire logic            lead_evt = da_cfg_i.lead_rise ? da_rise : da_fall;
   wire logic            trail_evt = da_cfg_i.lead_rise ? da_fall : da_rise;
   wire logic            mode_chg = da_cfg_i.mode != mode_q_r;
   wire logic            a_match  = da_step & masked_match(da_tb, a_r, da_cfg_i.mask_bits);
   wire logic            b_match  = da_step & masked_match(da_tb, b2_r, da_cfg_i.mask_bits);
   wire logic            lead_lvl = da_cfg_i.lead_rise;

   // Next-state logic; compares only fire on a time-base step so each value matches once.
   always_comb
   begin
      a_nxt     = a_r;
      b1_nxt    = b1_r;
      b2_nxt    = b2_r;
      copy_nxt  = 1'b0;
      first_nxt = first_r;
      a_arm_nxt = a_arm_r;
      b_arm_nxt = b_arm_r;
      out_nxt   = out_r;
      irq_nxt   = 1'b0;
      if (mode_chg)
      begin
         first_nxt = 1'b1;
         a_arm_nxt = 1'b0;
         b_arm_nxt = 1'b0;
         out_nxt   = ~lead_lvl;
      end
      else
      begin
         case (da_cfg_i.mode)
            DA_PULSE_WIDTH:
            begin
               if (lead_evt)
               begin
                  b1_nxt    = da_tb;
                  irq_nxt   = da_cfg_i.first_irq_en;
               end
               if (trail_evt)
               begin
                  a_nxt   = da_tb;
                  b2_nxt  = b1_r;
                  irq_nxt = da_cfg_i.irq_en;
               end
            end
            DA_PERIOD:
            begin
               // The pending copy lands before a new edge can move the first stage on.
               if (copy_r)
                  b1_nxt = a_r;
               if (lead_evt)
               begin
                  a_nxt     = da_tb;
                  b2_nxt    = b1_r;
                  copy_nxt  = 1'b1;
                  first_nxt = 1'b0;
                  irq_nxt   = da_cfg_i.irq_en | (da_cfg_i.first_irq_en & first_r);
               end
            end
            DA_ONE_SHOT:
            begin
               if (a_arm_r && a_match)
               begin
                  out_nxt   = lead_lvl;
                  a_arm_nxt = 1'b0;
                  irq_nxt   = da_cfg_i.irq_en & (da_cfg_i.irq_every_edge | ~b_arm_r);
               end
               if (b_arm_r && b_match)
               begin
                  out_nxt   = ~lead_lvl;
                  b_arm_nxt = 1'b0;
                  irq_nxt   = da_cfg_i.irq_en;
               end
            end
            DA_PWM:
            begin
               // New widths reach the second stage only here, so every pulse is whole.
               if (a_match)
               begin
                  out_nxt = lead_lvl;
                  b2_nxt  = b1_r;
                  irq_nxt = da_cfg_i.irq_en;
               end
               else if (b_match)
                  out_nxt = ~lead_lvl;
            end
            default:
            begin
               out_nxt = out_r;
            end
         endcase
         // Software writes arm the compares; one-shot B writes go straight to the second stage.
         if (da_wr_a_i)
         begin
            a_nxt     = da_wdata_i;
            a_arm_nxt = 1'b1;
         end
         if (da_wr_b_i)
         begin
            if (da_cfg_i.mode == DA_ONE_SHOT)
            begin
               b2_nxt    = da_wdata_i;
               b_arm_nxt = 1'b1;
            end
            else
               b1_nxt = da_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         a_r      <= TB_ZERO;
         b1_r     <= TB_ZERO;
         b2_r     <= TB_ZERO;
         copy_r   <= 1'b0;
         first_r  <= 1'b1;
         a_arm_r  <= 1'b0;
         b_arm_r  <= 1'b0;
         out_r    <= 1'b0;
         irq_r    <= 1'b0;
         mode_q_r <= DA_OFF;
      end
      else
      begin
         a_r      <= a_nxt;
         b1_r     <= b1_nxt;
         b2_r     <= b2_nxt;
         copy_r   <= copy_nxt;
         first_r  <= first_nxt;
         a_arm_r  <= a_arm_nxt;
         b_arm_r  <= b_arm_nxt;
         out_r    <= out_nxt;
         irq_r    <= irq_nxt;
         mode_q_r <= da_cfg_i.mode;
      end
   end

   // In pulse-width and period modes both halves change on the same edge, so the pair is a matched sample.
   assign da_pair_o     = '{primary: a_r, second: b2_r};
   assign da_first_o    = b1_r;
   assign da_pin_o      = out_r;
   assign da_pin_oe_n_o = ~((mode_q_r == DA_ONE_SHOT) | (mode_q_r == DA_PWM));
   assign da_irq_o      = irq_r;

   // ---- Single-action channel ----

   logic [TB_W-1:0] sa_a_r;
   logic [TB_W-1:0] sa_a_nxt;
   logic            sa_arm_r;
   logic            sa_arm_nxt;
   logic            sa_out_r;
   logic            sa_out_nxt;
   logic            sa_irq_r;
   logic            sa_irq_nxt;

   wire logic [TB_W-1:0] sa_tb    = sa_cfg_i.tb_sel ? mc_count : fr_count;
   wire logic            sa_step  = sa_cfg_i.tb_sel ? mc_step : fr_step;
   wire logic            sa_evt   = sa_cfg_i.cap_rise ? sa_rise : sa_fall;
   wire logic            sa_match = sa_step & sa_arm_r & (sa_tb == sa_a_r);

   // Capture or compare; a compare fires once and waits for a new value.
   always_comb
   begin
      sa_a_nxt   = sa_a_r;
      sa_arm_nxt = sa_arm_r;
      sa_out_nxt = sa_out_r;
      sa_irq_nxt = 1'b0;
      if (!sa_cfg_i.compare && sa_evt)
      begin
         sa_a_nxt   = sa_tb;
         sa_irq_nxt = sa_cfg_i.irq_en;
      end
      if (sa_cfg_i.compare && sa_match)
      begin
         case (sa_cfg_i.action)
            SA_TOGGLE:     sa_out_nxt = ~sa_out_r;
            SA_FORCE_HIGH: sa_out_nxt = 1'b1;
            SA_FORCE_LOW:  sa_out_nxt = 1'b0;
            default:       sa_out_nxt = sa_out_r;
         endcase
         sa_arm_nxt = 1'b0;
         sa_irq_nxt = sa_cfg_i.irq_en;
      end
      if (sa_wr_i)
      begin
         sa_a_nxt   = sa_wdata_i;
         sa_arm_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sa_a_r   <= TB_ZERO;
         sa_arm_r <= 1'b0;
         sa_out_r <= 1'b0;
         sa_irq_r <= 1'b0;
      end
      else
      begin
         sa_a_r   <= sa_a_nxt;
         sa_arm_r <= sa_arm_nxt;
         sa_out_r <= sa_out_nxt;
         sa_irq_r <= sa_irq_nxt;
      end
   end

   assign sa_capture_o  = sa_a_r;
   assign sa_pin_o      = sa_out_r;
   assign sa_pin_oe_n_o = ~sa_cfg_i.compare;
   assign sa_irq_o      = sa_irq_r;

   // ---- Checks ----

   chk_lead_capture : assert property (@(posedge clk_i) disable iff (rst_i)
      (da_cfg_i.mode == DA_PULSE_WIDTH && !mode_chg && lead_evt && !da_wr_b_i)
      |=> b1_r == $past(da_tb))
      else $error("Leading edge did not capture into the first stage.");

   chk_trail_shift : assert property (@(posedge clk_i) disable iff (rst_i)
      (da_cfg_i.mode == DA_PULSE_WIDTH && !mode_chg && trail_evt && !da_wr_a_i)
      |=> a_r == $past(da_tb) && b2_r == $past(b1_r))
      else $error("Trailing edge did not capture and shift.");

   chk_trail_request : assert property (@(posedge clk_i) disable iff (rst_i)
      (da_cfg_i.mode == DA_PULSE_WIDTH && !mode_chg && trail_evt && da_cfg_i.irq_en)
      |=> da_irq_o)
      else $error("No request after trailing edge.");

   chk_period_copy : assert property (@(posedge clk_i) disable iff (rst_i)
      (da_cfg_i.mode == DA_PERIOD && !mode_chg && lead_evt && !da_wr_a_i)
      ##1 (da_cfg_i.mode == DA_PERIOD && !da_wr_b_i)
      |=> b1_r == $past(a_r))
      else $error("Primary not copied into first stage after period edge.");

   chk_pwm_width_sync : assert property (@(posedge clk_i) disable iff (rst_i)
      (da_cfg_i.mode == DA_PWM && !mode_chg && a_match)
      |=> b2_r == $past(b1_r) && da_pin_o == $past(lead_lvl))
      else $error("Leading match did not drive output and load trailing time.");

   chk_oneshot_halt : assert property (@(posedge clk_i) disable iff (rst_i)
      (da_cfg_i.mode == DA_ONE_SHOT && !a_arm_r && !b_arm_r && !da_wr_a_i && !da_wr_b_i && !mode_chg)
      |=> $stable(da_pin_o))
      else $error("One-shot output moved while halted.");

   chk_sa_toggle : assert property (@(posedge clk_i) disable iff (rst_i)
      (sa_cfg_i.compare && sa_match && sa_cfg_i.action == SA_TOGGLE)
      |=> sa_pin_o != $past(sa_pin_o))
      else $error("Toggle action did not invert the output.");

   chk_sa_request : assert property (@(posedge clk_i) disable iff (rst_i)
      (sa_cfg_i.compare && sa_match && sa_cfg_i.irq_en) |=> sa_irq_o ##1 !sa_irq_o)
      else $error("Compare completion request missing or stuck.");

endmodule
`default_nettype wire

// >>> sim/dcc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side signal source: one high pulse of width_i cycles per go_i request.
module dcc_pin_model
(
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic [7:0] width_i,
   output logic            pin_o
);
   logic [7:0] left_r = 8'h00;

   // The pin idles low between pulses, so each pulse has a clean leading edge.
   always_ff @(posedge clk_i)
   begin
      if (go_i)
         left_r <= width_i;
      else if (left_r != 8'h00)
         left_r <= left_r - 8'h01;
   end
   assign pin_o = (left_r != 8'h00);
endmodule

`default_nettype wire

// >>> sim/dual_edge_capture_compare_channel_test.sv
`timescale 1ns/1ps
`default_nettype none

module dual_edge_capture_compare_channel_test;
   import dcc_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, tick = 1'b1, frl = 1'b0, mcl = 1'b0, wa = 1'b0, wb = 1'b0, sw = 1'b0;
   logic go = 1'b0, dpin, dpo, doe, dirq, fro, mco, spo, soe, sirq, seen;
   logic [7:0] wid = 8'h00;
   logic [TB_W-1:0] lval = 16'h0000, mmod = 16'h0000, swd = 16'h0000, dwd = 16'h0000, frn, mcn, first, scap;
   dcc_cnt_cfg_t frc = '0, mcc = '0;
   dcc_da_cfg_t dac = '0;
   dcc_sa_cfg_t sac = '0;
   dcc_pair_t pair;
   int n_mismatch = 0, checks_done = 0, cyc = 0;

   // Free-running clock at 100 MHz.
   initial
   begin
      forever #5 clk_i = ~clk_i;
   end

   dcc_pin_model pin_u (.clk_i(clk_i), .go_i(go), .width_i(wid), .pin_o(dpin));

   dcc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .presc_tick_i(tick), .cnt_pin_i(dpin), .fr_cfg_i(frc),
      .mc_cfg_i(mcc), .fr_load_i(frl), .mc_load_i(mcl), .cnt_load_val_i(lval), .mc_modulus_i(mmod),
      .fr_count_o(frn), .mc_count_o(mcn), .fr_ovf_irq_o(fro), .mc_ovf_irq_o(mco), .da_cfg_i(dac),
      .da_wr_a_i(wa), .da_wr_b_i(wb), .da_wdata_i(dwd), .da_pin_i(dpin), .da_pin_o(dpo),
      .da_pin_oe_n_o(doe), .da_pair_o(pair), .da_first_o(first), .da_irq_o(dirq), .sa_cfg_i(sac),
      .sa_wr_i(sw), .sa_wdata_i(swd), .sa_pin_i(dpin), .sa_pin_o(spo), .sa_pin_oe_n_o(soe),
      .sa_capture_o(scap), .sa_irq_o(sirq));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Verdict is given in one place, also when the cycle limit cuts a hang short.
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // A modulus unit loaded with all ones wraps to its modulus and flags the overflow.
   task automatic t_mod_wrap();
      @(posedge clk_i);
      mcc <= '{src_ext: 1'b0, ext_rise: 1'b0, ovf_irq_en: 1'b1};
      frc <= '{src_ext: 1'b0, ext_rise: 1'b0, ovf_irq_en: 1'b1};
      mmod <= 16'hfff3;
      lval <= 16'hffff;
      mcl <= 1'b1;
      frl <= 1'b1;
      @(posedge clk_i);
      mcl <= 1'b0;
      frl <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("mc_count", 32'h0000fff3, {16'h0000, mcn});
      chk("mc_ovf", 32'h1, {31'h0, mco});
      chk("fr_count", 32'h0, {16'h0000, frn});
      chk("fr_ovf", 32'h1, {31'h0, fro});
      $display("test mod_wrap done");
   endtask

   // Pulse width: both edges share the capture latency, so the sample difference is the width.
   task automatic t_pulse_width();
      @(posedge clk_i);
      dac <= '{mode: DA_PULSE_WIDTH, tb_sel: 1'b0, lead_rise: 1'b1, irq_en: 1'b1, default: '0};
      mcc <= '{src_ext: 1'b1, ext_rise: 1'b1, ovf_irq_en: 1'b1};
      mcl <= 1'b1;
      repeat (4) @(posedge clk_i);
      mcl <= 1'b0;
      go <= 1'b1;
      wid <= 8'h0d;
      @(posedge clk_i);
      go <= 1'b0;
      seen = 1'b0;
      for (int i = 0; i < 40 && seen !== 1'b1; i++)
      begin
         @(posedge clk_i);
         #1;
         seen = dirq;
      end
      chk("da_irq", 32'h1, {31'h0, seen});
      chk("pw_width", 32'h0000000d, {16'h0000, pair.primary - pair.second});
      chk("mc_pulses", 32'h0000fff3, {16'h0000, mcn});
      chk("sa_fall_cap", 32'h0000000d, {16'h0000, scap - pair.second});
      chk("sa_oe_n", 32'h1, {31'h0, soe});
      $display("test pulse_width done");
   endtask

   // Period: rising edges 21 cycles apart; the first stage then holds a copy of the primary.
   task automatic t_period();
      @(posedge clk_i);
      dac <= '{mode: DA_PERIOD, tb_sel: 1'b0, lead_rise: 1'b1, irq_en: 1'b1, default: '0};
      wid <= 8'h04;
      repeat (2)
      begin
         repeat (20) @(posedge clk_i);
         go <= 1'b1;
         @(posedge clk_i);
         go <= 1'b0;
      end
      repeat (6) @(posedge clk_i);
      #1;
      chk("per_span", 32'h00000015, {16'h0000, pair.primary - pair.second});
      chk("per_copy", 32'h0, {16'h0000, first - pair.primary});
      $display("test period done");
   endtask

   // PWM on the low four time-base bits: lead at 2, trail at 8, six cycles high in sixteen.
   task automatic t_pwm();
      @(posedge clk_i);
      dac <= '{mode: DA_PWM, tb_sel: 1'b0, lead_rise: 1'b1, irq_en: 1'b1, mask_bits: 4'hc, default: '0};
      @(posedge clk_i);
      dwd <= 16'h0002;
      wa <= 1'b1;
      @(posedge clk_i);
      wa <= 1'b0;
      dwd <= 16'h0008;
      wb <= 1'b1;
      @(posedge clk_i);
      wb <= 1'b0;
      seen = 1'b0;
      for (int i = 0; i < 40 && seen !== 1'b1; i++)
      begin
         @(posedge clk_i);
         #1;
         seen = dirq;
      end
      chk("pwm_irq", 32'h1, {31'h0, seen});
      chk("pwm_oe_n", 32'h0, {31'h0, doe});
      chk("pwm_lead", 32'h1, {31'h0, dpo});
      chk("pwm_pair", 32'h00020008, pair);
      @(posedge clk_i);
      dwd <= 16'h000a;
      wb <= 1'b1;
      @(posedge clk_i);
      wb <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      chk("pwm_high", 32'h1, {31'h0, dpo});
      chk("pwm_first", 32'h0000000a, {16'h0000, first});
      @(posedge clk_i);
      #1;
      chk("pwm_trail", 32'h0, {31'h0, dpo});
      $display("test pwm done");
   endtask

   // Single-action compare forcing the pin high at a value ahead of the count.
   task automatic t_sa_compare();
      @(posedge clk_i);
      sac <= '{compare: 1'b1, tb_sel: 1'b0, cap_rise: 1'b0, action: SA_FORCE_HIGH, irq_en: 1'b1};
      swd <= frn + 16'h0020;
      sw <= 1'b1;
      @(posedge clk_i);
      sw <= 1'b0;
      seen = 1'b0;
      for (int i = 0; i < 60 && seen !== 1'b1; i++)
      begin
         @(posedge clk_i);
         #1;
         seen = sirq;
      end
      chk("sa_irq", 32'h1, {31'h0, seen});
      chk("sa_pin", 32'h1, {31'h0, spo});
      chk("sa_cmp_val", {16'h0000, swd}, {16'h0000, scap});
      chk("sa_oe_n_cmp", 32'h0, {31'h0, soe});
      $display("test sa_compare done");
   endtask

   // Cycle ceiling well above the roughly 140 cycles the tests need.
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         close_out();
      end
   end

   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("pair_rst", 32'h0, pair);
      t_mod_wrap();
      t_pulse_width();
      t_period();
      t_pwm();
      t_sa_compare();
      close_out();
   end
endmodule

`default_nettype wire
